// *** common/twi_pkg.sv ***
/*
 * Shared constants for the two-wire EEPROM slave and its bus master.
 * Assumes a single 40 MHz system clock on both ends.
 */
package twi_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    // Internal program time, longest figure, rounded down
    localparam int PROG_TIME_NS = 5_000_000;
    localparam int PROG_CYC = PROG_TIME_NS / CLK_PERIOD_NS;
    // Quarter of an SCL period made by the master, least, rounded up
    localparam int SCL_QTR_NS = 250;
    localparam int SCL_QTR_CYC =
        (SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ----------------------------------------
    // Framing and array
    // ----------------------------------------
    localparam int BYTE_W = 8;
    localparam int ACK_BIT = 8;
    localparam int PAGE_BYTES = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int SYNC_LEN = 3;
    localparam int ARRAY_WORDS = 256;
    localparam logic [7:0] ADDR_MASK_1K = 8'h7F;
    localparam logic [7:0] ADDR_MASK_2K = 8'hFF;
    localparam logic [2:0] PAGE_OFS_MASK = 3'h7;
    // ----------------------------------------
    // Master commands
    // ----------------------------------------
    typedef enum logic [1:0] {
        CMD_START = 2'b00,
        CMD_STOP = 2'b01,
        CMD_WRITE = 2'b10,
        CMD_READ = 2'b11
    } cmd_kind_e;
endpackage

// *** common/twi_if.sv ***
/*
 * Two-wire link between master and EEPROM slave.
 * SDA is open drain: the wire is low while any party pulls it low.
 * SCL is made by the master alone.
 */
interface twi_if;
    logic scl;
    logic sda_host_o;
    logic sda_host_oe_n;
    logic sda_dev_o;
    logic sda_dev_oe_n;
    logic sda;

    // ----------------------------------------
    // Wired-AND of both drivers, pulled up when released
    // ----------------------------------------
    assign sda = !((!sda_host_oe_n && !sda_host_o) ||
                   (!sda_dev_oe_n && !sda_dev_o));

    modport host (
        output scl,
        output sda_host_o,
        output sda_host_oe_n,
        input sda
    );
    modport dev (
        input scl,
        output sda_dev_o,
        output sda_dev_oe_n,
        input sda
    );
endinterface

// *** rtl/twi_eeprom_dev.sv ***
/*
 * EEPROM slave end of the two-wire link, with its page FIFO.
 * Assumes SCL and SDA arrive from the link unsynchronised and that
 * the master keeps the bus rules on its side.
 */
// Functional notes
// - 1K variant: 16 pages, 7-bit address
// - 2K variant: 32 pages, 8-bit address
// - SDA changes only while SCL low
// - Start required before any command
// - Stop after read enters standby
// - Standby at power-up and after operations
// - Eight data bits plus one acknowledge
// - Device pulls SDA low on ninth clock
// - Start, nine clocks, Start, Stop recovers
// - Program cycle lasts at most 5 ms
// - Sample on SCL rise, launch on fall
// - Device only pulls low or releases
// - No acknowledge during program cycle
// - Write-protect high inhibits array writes

// ----------------------------------------
// Page FIFO
// ----------------------------------------
module twi_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic full;
    logic empty;

    assign empty = (wr_q == rd_q);
    assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_q[AW-1:0]];

    always_ff @(posedge clk) begin
        if (in_valid && !full) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || clr) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (in_valid && !full) begin
                wr_q <= wr_q + 1'b1;
            end
            if (out_ready && !empty) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule // twi_fifo

// ----------------------------------------
// EEPROM slave
// ----------------------------------------
module twi_eeprom_dev
    import twi_pkg::*;
#(
    parameter bit TWO_KBIT = 1'b1,
    parameter int PROG_CYCLES = PROG_CYC
) (
    input wire logic CLK,
    input wire logic RSTN,
    twi_if.dev BUS,
    input wire logic WP,
    output logic STANDBY,
    output logic PROG_BUSY
);
    typedef enum logic [2:0] {
        ST_STANDBY = 3'b000,
        ST_RX = 3'b001,
        ST_ACK = 3'b010,
        ST_TX = 3'b011,
        ST_MACK = 3'b100,
        ST_PROG = 3'b101
    } state_e;

    state_e state_q;
    logic [SYNC_LEN-1:0] scl_sync_q;
    logic [SYNC_LEN-1:0] sda_sync_q;
    logic [SYNC_LEN-1:0] wp_sync_q;
    logic scl_q;
    logic sda_q;
    logic wp_q;
    logic scl_prev_q;
    logic sda_prev_q;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic [3:0] bit_cnt_q;
    logic [1:0] byte_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    logic [7:0] addr_q;
    logic [7:0] prog_addr_q;
    logic rw_q;
    logic mack_q;
    logic wr_pend_q;
    logic sda_oe_n_q;
    logic push_q;
    logic [31:0] prog_cnt_q;
    logic fifo_ready;
    logic fifo_valid;
    logic [7:0] fifo_data;
    logic fifo_clr;
    logic [7:0] array_q [ARRAY_WORDS];

    // Word address limited to the variant's array size
    function automatic logic [7:0] mask_addr(input logic [7:0] a);
        return a & (TWO_KBIT ? ADDR_MASK_2K : ADDR_MASK_1K);
    endfunction

    // Next address inside the same page
    function automatic logic [7:0] page_inc(input logic [7:0] a);
        return mask_addr({a[7:3], (a[2:0] + 3'h1) & PAGE_OFS_MASK});
    endfunction

    // ----------------------------------------
    // Pin synchronisers and filters
    // ----------------------------------------
    // A level counts only once the second and third stages agree
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            scl_sync_q <= 3'h7;
            sda_sync_q <= 3'h7;
            wp_sync_q <= 3'h0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            wp_q <= 1'b0;
        end else begin
            scl_sync_q <= {scl_sync_q[1:0], BUS.scl};
            sda_sync_q <= {sda_sync_q[1:0], BUS.sda};
            wp_sync_q <= {wp_sync_q[1:0], WP};
            if (scl_sync_q[2] == scl_sync_q[1]) begin
                scl_q <= scl_sync_q[2];
            end
            if (sda_sync_q[2] == sda_sync_q[1]) begin
                sda_q <= sda_sync_q[2];
            end
            if (wp_sync_q[2] == wp_sync_q[1]) begin
                wp_q <= wp_sync_q[2];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_q;
            sda_prev_q <= sda_q;
        end
    end

    assign scl_rise = scl_q && !scl_prev_q;
    assign scl_fall = !scl_q && scl_prev_q;
    // SDA moving under a steady high SCL is framing, never data
    assign start_det = scl_q && scl_prev_q && sda_prev_q && !sda_q;
    assign stop_det = scl_q && scl_prev_q && !sda_prev_q && sda_q;
    // A write never closed by Stop is dropped on the next Start
    assign fifo_clr = start_det && (state_q != ST_PROG);

    // ----------------------------------------
    // Link state machine
    // ----------------------------------------
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            state_q <= ST_STANDBY;
            bit_cnt_q <= 4'h0;
            byte_cnt_q <= 2'h0;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            addr_q <= 8'h00;
            prog_addr_q <= 8'h00;
            rw_q <= 1'b0;
            mack_q <= 1'b0;
            wr_pend_q <= 1'b0;
            sda_oe_n_q <= 1'b1;
            push_q <= 1'b0;
        end else begin
            push_q <= 1'b0;
            if (state_q == ST_PROG) begin
                // Inputs are ignored until prog_cnt_q reaches zero, long after the array update ends
                sda_oe_n_q <= 1'b1;
                if (prog_cnt_q == 32'h0000_0000) begin
                    state_q <= ST_STANDBY;
                    wr_pend_q <= 1'b0;
                end
            end else if (start_det) begin
                state_q <= ST_RX;
                bit_cnt_q <= 4'h0;
                byte_cnt_q <= 2'h0;
                sda_oe_n_q <= 1'b1;
                wr_pend_q <= 1'b0;
            end else if (stop_det) begin
                bit_cnt_q <= 4'h0;
                sda_oe_n_q <= 1'b1;
                state_q <= wr_pend_q ? ST_PROG : ST_STANDBY;
            end else begin
                case (state_q)
                    ST_RX: begin
                        if (scl_rise && bit_cnt_q != 4'(ACK_BIT)) begin
                            shift_q <= {shift_q[6:0], sda_q};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (scl_fall && bit_cnt_q == 4'(ACK_BIT)) begin
                            state_q <= ST_ACK;
                            sda_oe_n_q <= 1'b0;
                            if (byte_cnt_q != 2'h3) begin
                                byte_cnt_q <= byte_cnt_q + 2'h1;
                            end
                            case (byte_cnt_q)
                                2'h0: rw_q <= shift_q[0];
                                2'h1: begin
                                    addr_q <= mask_addr(shift_q);
                                    prog_addr_q <= mask_addr(shift_q);
                                end
                                default: begin
                                    // Full page buffer: refuse the byte
                                    if (!fifo_ready) begin
                                        sda_oe_n_q <= 1'b1;
                                        state_q <= ST_STANDBY;
                                    end else begin
                                        addr_q <= page_inc(addr_q);
                                        if (!wp_q) begin
                                            push_q <= 1'b1;
                                            wr_pend_q <= 1'b1;
                                        end
                                    end
                                end
                            endcase
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            bit_cnt_q <= 4'h0;
                            if (rw_q) begin
                                tx_q <= array_q[addr_q];
                                sda_oe_n_q <= array_q[addr_q][7];
                                state_q <= ST_TX;
                            end else begin
                                sda_oe_n_q <= 1'b1;
                                state_q <= ST_RX;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_rise) begin
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt_q == 4'(ACK_BIT)) begin
                                sda_oe_n_q <= 1'b1;
                                state_q <= ST_MACK;
                            end else begin
                                tx_q <= {tx_q[6:0], 1'b0};
                                sda_oe_n_q <= tx_q[6];
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise) begin
                            mack_q <= !sda_q;
                        end else if (scl_fall) begin
                            addr_q <= mask_addr(addr_q + 8'h01);
                            bit_cnt_q <= 4'h0;
                            if (mack_q) begin
                                tx_q <= array_q[mask_addr(addr_q + 8'h01)];
                                sda_oe_n_q <=
                                    array_q[mask_addr(addr_q + 8'h01)][7];
                                state_q <= ST_TX;
                            end else begin
                                // No master ack: wait released for Stop
                                state_q <= ST_STANDBY;
                            end
                        end
                    end
                    default: begin
                        sda_oe_n_q <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Program cycle
    // ----------------------------------------
    // The full time is always spent, so the master's polling sees a
    // fixed busy window regardless of how many bytes were buffered
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            prog_cnt_q <= 32'h0000_0000;
        end else if (state_q != ST_PROG) begin
            prog_cnt_q <= 32'(PROG_CYCLES - 1);
        end else if (prog_cnt_q != 32'h0000_0000) begin
            prog_cnt_q <= prog_cnt_q - 32'h0000_0001;
        end
    end

    logic [7:0] wr_addr_q;
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            wr_addr_q <= 8'h00;
        end else if (state_q != ST_PROG) begin
            wr_addr_q <= prog_addr_q;
        end else if (fifo_valid) begin
            wr_addr_q <= page_inc(wr_addr_q);
        end
    end

    // Array contents are not reset, as in a real non-volatile part
    always_ff @(posedge CLK) begin
        if (state_q == ST_PROG && fifo_valid) begin
            array_q[wr_addr_q] <= fifo_data;
        end
    end

    twi_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_page_fifo (
        .clk(CLK),
        .rst_n(RSTN),
        .clr(fifo_clr),
        .in_valid(push_q),
        .in_ready(fifo_ready),
        .in_data(shift_q),
        .out_valid(fifo_valid),
        .out_ready(state_q == ST_PROG),
        .out_data(fifo_data)
    );

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            STANDBY <= 1'b1;
            PROG_BUSY <= 1'b0;
        end else begin
            STANDBY <= (state_q == ST_STANDBY);
            PROG_BUSY <= (state_q == ST_PROG);
        end
    end

    assign BUS.sda_dev_o = 1'b0;
    assign BUS.sda_dev_oe_n = sda_oe_n_q;
endmodule // twi_eeprom_dev

// *** rtl/twi_master_host.sv ***
/*
 * Bus master end of the two-wire link.
 * Makes SCL from CLK by a divider; SDA is read back through
 * synchronisers. User side issues one bus command at a time.
 */
module twi_master_host
    import twi_pkg::*;
#(
    parameter int QTR_CYCLES = SCL_QTR_CYC
) (
    input wire logic CLK,
    input wire logic RSTN,
    twi_if.host BUS,
    input wire logic CMD_VALID,
    input wire logic [1:0] CMD_KIND,
    input wire logic [7:0] CMD_DATA,
    input wire logic CMD_ACK,
    output logic CMD_READY,
    output logic RSP_VALID,
    output logic [7:0] RSP_DATA,
    output logic RSP_ACKED
);
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_START = 2'b01,
        H_STOP = 2'b10,
        H_BIT = 2'b11
    } hstate_e;

    hstate_e state_q;
    logic [15:0] qcnt_q;
    logic [1:0] step_q;
    logic [3:0] idx_q;
    logic [1:0] kind_q;
    logic [7:0] data_q;
    logic ack_q;
    logic [7:0] rx_q;
    logic acked_q;
    logic scl_q;
    logic sda_oe_n_q;
    logic [SYNC_LEN-1:0] sda_sync_q;
    logic sda_q;
    logic tick;

    // Release (1) or pull low (0) for bit idx of a byte command
    function automatic logic bit_level(
        input logic [1:0] kind,
        input logic [7:0] data,
        input logic ack,
        input logic [3:0] idx
    );
        logic lvl;
        lvl = 1'b1;
        if (kind == CMD_WRITE && idx < 4'(ACK_BIT)) begin
            lvl = data[3'(7 - idx)];
        end else if (kind == CMD_READ && idx == 4'(ACK_BIT)) begin
            lvl = !ack;
        end
        return lvl;
    endfunction

    // ----------------------------------------
    // SDA read-back
    // ----------------------------------------
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            sda_sync_q <= 3'h7;
            sda_q <= 1'b1;
        end else begin
            sda_sync_q <= {sda_sync_q[1:0], BUS.sda};
            if (sda_sync_q[2] == sda_sync_q[1]) begin
                sda_q <= sda_sync_q[2];
            end
        end
    end

    assign tick = (state_q != H_IDLE) && (qcnt_q == 16'h0000);

    // ----------------------------------------
    // Quarter-period divider
    // ----------------------------------------
    always_ff @(posedge CLK) begin
        if (!RSTN || state_q == H_IDLE || tick) begin
            qcnt_q <= 16'(QTR_CYCLES - 1);
        end else begin
            qcnt_q <= qcnt_q - 16'h0001;
        end
    end

    // ----------------------------------------
    // Bus sequencer
    // ----------------------------------------
    // SDA only moves a quarter into SCL low, except on purpose in the
    // Start and Stop sequences
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            state_q <= H_IDLE;
            step_q <= 2'h0;
            idx_q <= 4'h0;
            kind_q <= 2'h0;
            data_q <= 8'h00;
            ack_q <= 1'b0;
            rx_q <= 8'h00;
            acked_q <= 1'b0;
            scl_q <= 1'b1;
            sda_oe_n_q <= 1'b1;
            CMD_READY <= 1'b1;
            RSP_VALID <= 1'b0;
            RSP_DATA <= 8'h00;
            RSP_ACKED <= 1'b0;
        end else begin
            RSP_VALID <= 1'b0;
            case (state_q)
                H_IDLE: begin
                    if (CMD_VALID && CMD_READY) begin
                        CMD_READY <= 1'b0;
                        kind_q <= CMD_KIND;
                        data_q <= CMD_DATA;
                        ack_q <= CMD_ACK;
                        step_q <= 2'h0;
                        idx_q <= 4'h0;
                        case (CMD_KIND)
                            CMD_START: begin
                                state_q <= H_START;
                                sda_oe_n_q <= 1'b1;
                            end
                            CMD_STOP: begin
                                state_q <= H_STOP;
                                sda_oe_n_q <= 1'b0;
                            end
                            default: begin
                                state_q <= H_BIT;
                                sda_oe_n_q <= bit_level(CMD_KIND,
                                    CMD_DATA, CMD_ACK, 4'h0);
                            end
                        endcase
                    end
                end
                default: begin
                    if (tick) begin
                        step_q <= step_q + 2'h1;
                        case (step_q)
                            2'h0: begin
                                scl_q <= 1'b1;
                            end
                            2'h1: begin
                                if (state_q == H_START) begin
                                    sda_oe_n_q <= 1'b0;
                                end else if (state_q == H_STOP) begin
                                    sda_oe_n_q <= 1'b1;
                                end
                            end
                            2'h2: begin
                                if (state_q == H_BIT) begin
                                    scl_q <= 1'b0;
                                    if (idx_q < 4'(ACK_BIT)) begin
                                        rx_q <= {rx_q[6:0], sda_q};
                                    end else begin
                                        acked_q <= !sda_q;
                                    end
                                end else if (state_q == H_START) begin
                                    scl_q <= 1'b0;
                                end
                            end
                            default: begin
                                if (state_q == H_BIT &&
                                    idx_q != 4'(ACK_BIT)) begin
                                    idx_q <= idx_q + 4'h1;
                                    sda_oe_n_q <= bit_level(kind_q,
                                        data_q, ack_q,
                                        idx_q + 4'h1);
                                end else begin
                                    if (state_q == H_BIT) begin
                                        sda_oe_n_q <= 1'b1;
                                    end
                                    state_q <= H_IDLE;
                                    CMD_READY <= 1'b1;
                                    RSP_VALID <= 1'b1;
                                    RSP_DATA <= rx_q;
                                    RSP_ACKED <= acked_q;
                                end
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    assign BUS.scl = scl_q;
    assign BUS.sda_host_o = 1'b0;
    assign BUS.sda_host_oe_n = sda_oe_n_q;
endmodule // twi_master_host

// *** verification/twi_link_properties.sv ***
/* Link checker for the device end of the two-wire bus.
   Assumes one CLK domain and the interface signals as inputs. */
module twi_link_properties #(parameter int PROG_CYCLES = 1) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe_n,
    input wire logic STANDBY,
    input wire logic PROG_BUSY
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // Counts busy cycles; exact length, not just an upper bound
    int cnt_q;
    always_ff @(posedge CLK) cnt_q <= (!RSTN || !PROG_BUSY) ? 0 : cnt_q + 1;
    a_dev_only_low: assert property (
        !sda_dev_oe_n |-> !sda_dev_o && !sda) else $error("sda not low");
    a_standby_quiet: assert property (
        STANDBY |-> sda_dev_oe_n) else $error("pull in standby");
    a_busy_no_ack: assert property (
        PROG_BUSY |-> sda_dev_oe_n) else $error("pull while busy");
    a_prog_length: assert property (
        $fell(PROG_BUSY) |-> cnt_q == PROG_CYCLES) else $error("prog len");
    a_prog_then_idle: assert property (
        $fell(PROG_BUSY) |-> ##[0:2] STANDBY) else $error("no standby");
    a_dev_edge_low: assert property (
        $changed(sda_dev_oe_n) |-> !scl) else $error("sda moved, scl high");
    a_launch_late: assert property (
        $fell(sda_dev_oe_n) |-> !$past(scl, 3)) else $error("early launch");
    a_hold_high: assert property (
        $rose(scl) && !sda_dev_oe_n |=> !sda_dev_oe_n [*8])
        else $error("pull dropped");
    c_prog: cover property ($rose(PROG_BUSY));
    c_pull: cover property ($rose(scl) && !sda_dev_oe_n);
    c_wake: cover property ($fell(STANDBY));
endmodule // twi_link_properties

// *** verification/i2c_eeprom_bus_conditions_tb.sv ***
/* Bench: host and EEPROM ends joined by one twi_if.
   Assumes PROG_CYCLES shortened to PC for run length. */
module i2c_eeprom_bus_conditions_tb import twi_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PC = 1500;
    logic clk = 0, rstn = 0, wp = 0, cv = 0, ca = 0;
    logic [1:0] ck = 0;
    logic [7:0] cd = 0, rd;
    logic rdy, rv, ra, sb, pb;
    int n_mismatch = 0, compares = 0;
    always #12.5 clk = !clk;
    twi_if bus ();
    twi_eeprom_dev #(.PROG_CYCLES(PC)) u_twi_eeprom_dev (.CLK(clk),
        .RSTN(rstn), .BUS(bus), .WP(wp), .STANDBY(sb), .PROG_BUSY(pb));
    twi_master_host u_twi_master_host (.CLK(clk), .RSTN(rstn), .BUS(bus),
        .CMD_VALID(cv), .CMD_KIND(ck), .CMD_DATA(cd), .CMD_ACK(ca),
        .CMD_READY(rdy), .RSP_VALID(rv), .RSP_DATA(rd), .RSP_ACKED(ra));
    twi_link_properties #(.PROG_CYCLES(PC)) u_chk (.CLK(clk), .RSTN(rstn),
        .scl(bus.scl), .sda(bus.sda), .sda_dev_o(bus.sda_dev_o),
        .sda_dev_oe_n(bus.sda_dev_oe_n), .STANDBY(sb), .PROG_BUSY(pb));
    task automatic check(string s, logic [7:0] got, logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", s, exp, got);
        end
    endtask
    task automatic give_verdict;
        $display("mismatches %0d, compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmd(logic [1:0] k, logic [7:0] d = 0, logic a = 0);
        int n = 0;
        @(negedge clk);
        ck = k;
        cd = d;
        ca = a;
        cv = 1;
        @(negedge clk);
        cv = 0;
        while (rv !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        // A command that never answers counts here, not as a hang
        check("done", 8'(rv), 1);
        check("ready", 8'(rdy), 1);
    endtask
    task automatic wr(logic [7:0] d, logic a);
        cmd(CMD_WRITE, d);
        check("ack", 8'(ra), 8'(a));
    endtask
    // Waits out any program cycle, then standby must show
    task automatic idle;
        int n = 0;
        while (pb !== 1'b0 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        repeat (4) @(negedge clk);
        check("standby", 8'(sb), 1);
    endtask
    task automatic t_write;
        cmd(CMD_START);
        wr(8'hA0, 1);
        wr(8'h88, 1);
        for (int i = 0; i < 8; i++) wr(8'(8'h40 + i), 1);
        cmd(CMD_STOP);
        check("busy", 8'(pb), 1);
        cmd(CMD_START);
        wr(8'hA0, 0);
        cmd(CMD_STOP);
        idle();
    endtask
    task automatic t_protect;
        wp = 1;
        cmd(CMD_START);
        wr(8'hA0, 1);
        wr(8'h88, 1);
        wr(8'hEE, 1);
        cmd(CMD_STOP);
        check("busy", 8'(pb), 0);
        wp = 0;
        idle();
    endtask
    task automatic t_read;
        cmd(CMD_START);
        wr(8'hA0, 1);
        wr(8'h88, 1);
        cmd(CMD_START);
        wr(8'hA1, 1);
        cmd(CMD_READ, 0, 1);
        check("rd0", rd, 8'h40);
        cmd(CMD_READ, 0, 0);
        check("rd1", rd, 8'h41);
        cmd(CMD_STOP);
        idle();
    endtask
    // Abandons a read whose next bit holds sda low
    task automatic t_recover;
        cmd(CMD_START);
        wr(8'hA1, 1);
        cmd(CMD_READ, 0, 1);
        cmd(CMD_START);
        cmd(CMD_READ);
        cmd(CMD_START);
        cmd(CMD_STOP);
        // After recovery a fresh control byte must be acknowledged
        cmd(CMD_START);
        wr(8'hA0, 1);
        cmd(CMD_STOP);
        idle();
    endtask
    task automatic t_fill;
        cmd(CMD_START);
        wr(8'hA0, 1);
        wr(8'h10, 1);
        for (int i = 0; i < 9; i++) wr(8'(i), i < 8);
        cmd(CMD_STOP);
        idle();
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rstn = 1;
        check("standby", 8'(sb), 1);
        t_write();
        t_protect();
        t_read();
        t_recover();
        t_fill();
        give_verdict();
    end
    initial begin
        repeat (80000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end
endmodule // i2c_eeprom_bus_conditions_tb
